/* File: rtl/nvap_pkg.sv */
package nvap_pkg;
   localparam logic [7:0] NV_ADDR_DATA_OFS = 8'h3e;
   localparam logic [7:0] NV_ACCESS_CTRL_OFS = 8'h3f;
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_DEC_HI = 6;
   localparam int CTRL_DEC_LO = 5;
   localparam logic [1:0] DEC_LOW_ADDR = 2'h0;
   localparam logic [1:0] DEC_HIGH_ADDR = 2'h1;
   localparam logic [1:0] DEC_WRITE = 2'h2;
   localparam logic [1:0] DEC_READ = 2'h3;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam int CLK_HZ = 50000000;
   localparam int SCL_DIVIDE = 512;
   localparam int SCL_HALF = SCL_DIVIDE / 2;
   localparam int BW_CYCLE = 8;
   localparam int BW_STROBE_FIRST = 1;
   localparam int BW_STROBE_LAST = 6;
   localparam logic [6:0] SER_DEV_READ = 7'h50;
endpackage : nvap_pkg

/* File: rtl/nvap_port.sv */
`timescale 1ns/10ps
//Contract
//- serial mode uses only clock and data lines
//- byte mode drives 16-bit address, 8-bit data
//- device times its own read, write strobes
//- rom region read does four byte reads
//- rom region writes never touch memory
//- 8-bit address/data latch in bits 23:16
//- 3-bit access control field in bits 31:29
//- enable set lets decode bits steer latch
//- top bit reads busy during memory access
//- 80h opens low, a0h high, captures low
//- c0h captures data, starts memory write
//- e0h captures address, starts memory read
//- written byte captured only on decode change, disable or write start
//- 00h captures pending byte, closes access
//- latched address never auto increments
//- address bytes persist across accesses
//- one wide write loads both bytes
//- only last written byte gets captured
//- serial clock is bus clock over 512
//- byte-wide reads have fixed length
module nvap_port
   import nvap_pkg::*;
#(
   parameter int BW_LEN = nvap_pkg::BW_CYCLE
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic SERIAL_MODE,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_OFS,
   input wire logic [1:0] REG_BE,
   input wire logic [15:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   input wire logic ROM_RD,
   input wire logic ROM_WR,
   input wire logic [15:0] ROM_ADDR,
   output logic ROM_ACK,
   output logic [31:0] ROM_RDATA,
   output logic [15:0] NV_ADDRESS_BUS,
   output logic [7:0] NV_DATA_BUS_OUT,
   output logic NV_DATA_BUS_OE_N,
   input wire logic [7:0] NV_DATA_BUS_IN,
   output logic NV_READ_STROBE_N,
   output logic NV_WRITE_STROBE_N,
   output logic SCL_OE_N,
   output logic SDA_OE_N,
   input wire logic SDA_IN
);
   import nvap_pkg::*;
   initial begin
      if (BW_LEN < BW_STROBE_LAST + 2) begin
         $error("nvap_port: BW_LEN too short for the strobe window");
      end
   end
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_BYTE = 4'b0010,
      ST_SER = 4'b0100,
      ST_NEXT = 4'b1000
   } nvap_state_t;
   typedef struct packed {
      nvap_state_t st;
      logic [7:0] hold;
      logic [2:0] ctrl;
      logic [7:0] alo;
      logic [7:0] ahi;
      logic [7:0] dat;
      logic busy;
      logic op_read;
      logic rom;
      logic [1:0] rom_idx;
      logic [15:0] cur_addr;
      logic [31:0] rom_word;
      logic rom_ack;
      logic [7:0] cyc;
      logic rd_n;
      logic wr_n;
      logic dq_oe_n;
      logic [7:0] rdata;
      logic ser_go;
      logic [1:0] mode_s;
      logic [1:0] sda_s;
   } nvap_t;
   nvap_t r, next_r;
   logic ser_done;
   logic [7:0] ser_rdata;
   logic ser_scl_oe_n;
   logic ser_sda_oe_n;
   logic [7:0] new_ctrl_byte;
   logic [7:0] new_hold;
   logic ctrl_wr;
   logic start_rd;
   logic start_wr;
   nvap_serial #(
      .DIVIDE(SCL_DIVIDE)
   ) u_serial (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .start(r.ser_go),
      .is_read(r.op_read),
      .addr(r.cur_addr),
      .wdata(r.dat),
      .sda_in(r.sda_s[1]),
      .scl_oe_n(ser_scl_oe_n),
      .sda_oe_n(ser_sda_oe_n),
      .done(ser_done),
      .rdata(ser_rdata)
   );
   always_comb begin
      next_r = r;
      next_r.rom_ack = 1'b0;
      next_r.ser_go = 1'b0;
      next_r.mode_s = {r.mode_s[0], SERIAL_MODE};
      next_r.sda_s = {r.sda_s[0], SDA_IN};
      start_rd = 1'b0;
      start_wr = 1'b0;
      new_hold = r.hold;
      new_ctrl_byte = {r.ctrl, 5'h00};
      ctrl_wr = 1'b0;
      // one 16-bit write may load data byte and control byte together
      if (REG_WR && REG_OFS == NV_ADDR_DATA_OFS && REG_BE[0]) begin
         new_hold = REG_WDATA[7:0];
      end
      if (REG_WR && REG_OFS == NV_ADDR_DATA_OFS && REG_BE[1]) begin
         new_ctrl_byte = REG_WDATA[15:8];
         ctrl_wr = 1'b1;
      end
      if (REG_WR && REG_OFS == NV_ACCESS_CTRL_OFS && REG_BE[0]) begin
         new_ctrl_byte = REG_WDATA[7:0];
         ctrl_wr = 1'b1;
      end
      next_r.hold = new_hold;
      // control writes are dropped while busy so the running access and
      // its latched address stay intact
      if (ctrl_wr && !r.busy) begin
         next_r.ctrl = new_ctrl_byte[7:5];
         // pending byte lands in the latch the old decode pointed at
         if (r.ctrl[2] && (r.ctrl[1:0] != new_ctrl_byte[6:5] ||
               !new_ctrl_byte[7])) begin
            case (r.ctrl[1:0])
               DEC_LOW_ADDR: next_r.alo = new_hold;
               DEC_HIGH_ADDR: next_r.ahi = new_hold;
               DEC_WRITE: next_r.dat = new_hold;
               default: next_r.alo = r.alo;
            endcase
         end
         if (new_ctrl_byte[7] && new_ctrl_byte[6:5] == DEC_WRITE &&
               !(r.ctrl[2] && r.ctrl[1:0] == DEC_WRITE)) begin
            start_wr = 1'b1;
            if (!(r.ctrl[2] && r.ctrl[1:0] != DEC_WRITE)) begin
               next_r.dat = new_hold;
            end
         end
         if (new_ctrl_byte[7] && new_ctrl_byte[6:5] == DEC_READ &&
               !(r.ctrl[2] && r.ctrl[1:0] == DEC_READ)) begin
            start_rd = 1'b1;
         end
      end
      case (r.st)
         ST_IDLE: begin
            next_r.rd_n = 1'b1;
            next_r.wr_n = 1'b1;
            next_r.dq_oe_n = 1'b1;
            if (start_rd || start_wr) begin
               // address is read from the latches including any byte this write captures
               next_r.busy = 1'b1;
               next_r.op_read = start_rd;
               next_r.rom = 1'b0;
               next_r.cur_addr = {next_r.ahi, next_r.alo};
               next_r.cyc = 8'h00;
               next_r.st = r.mode_s[1] ? ST_SER : ST_BYTE;
               next_r.ser_go = r.mode_s[1];
            end else if (ROM_RD && !r.rom_ack) begin
               next_r.busy = 1'b1;
               next_r.op_read = 1'b1;
               next_r.rom = 1'b1;
               next_r.rom_idx = 2'd0;
               next_r.cur_addr = {ROM_ADDR[15:2], 2'b00};
               next_r.cyc = 8'h00;
               next_r.st = r.mode_s[1] ? ST_SER : ST_BYTE;
               next_r.ser_go = r.mode_s[1];
            end else if (ROM_WR && !r.rom_ack) begin
               // rom window is read only: acknowledge and discard
               next_r.rom_ack = 1'b1;
            end
         end
         ST_BYTE: begin
            // every cycle has the same length; writes the same shape
            next_r.cyc = r.cyc + 8'h01;
            next_r.rd_n = !(r.op_read && r.cyc >= 8'(BW_STROBE_FIRST - 1)
               && r.cyc < 8'(BW_STROBE_LAST));
            next_r.wr_n = !(!r.op_read && r.cyc >= 8'(BW_STROBE_FIRST - 1)
               && r.cyc < 8'(BW_STROBE_LAST));
            next_r.dq_oe_n = r.op_read;
            if (r.cyc == 8'(BW_STROBE_LAST)) begin
               next_r.rdata = NV_DATA_BUS_IN;
            end
            if (r.cyc == 8'(BW_LEN - 1)) begin
               next_r.st = ST_NEXT;
            end
         end
         ST_SER: begin
            if (ser_done) begin
               next_r.rdata = ser_rdata;
               next_r.st = ST_NEXT;
            end
         end
         ST_NEXT: begin
            next_r.rd_n = 1'b1;
            next_r.wr_n = 1'b1;
            next_r.dq_oe_n = 1'b1;
            if (r.rom) begin
               next_r.rom_word[8*r.rom_idx +: 8] = r.rdata;
               if (r.rom_idx == 2'd3) begin
                  next_r.rom_ack = 1'b1;
                  next_r.busy = 1'b0;
                  next_r.st = ST_IDLE;
               end else begin
                  next_r.rom_idx = r.rom_idx + 2'd1;
                  next_r.cur_addr = r.cur_addr + 16'h0001;
                  next_r.cyc = 8'h00;
                  next_r.st = r.mode_s[1] ? ST_SER : ST_BYTE;
                  next_r.ser_go = r.mode_s[1];
               end
            end else begin
               if (r.op_read) begin
                  next_r.hold = r.rdata;
               end
               next_r.busy = 1'b0;
               next_r.st = ST_IDLE;
            end
         end
         default: next_r.st = ST_IDLE;
      endcase
   end
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         r <= '{st: ST_IDLE, hold: LATCH_RESET, ctrl: 3'h0,
                alo: LATCH_RESET, ahi: LATCH_RESET, dat: LATCH_RESET,
                busy: 1'b0, op_read: 1'b0, rom: 1'b0, rom_idx: 2'h0,
                cur_addr: 16'h0000, rom_word: 32'h00000000,
                rom_ack: 1'b0, cyc: 8'h00, rd_n: 1'b1, wr_n: 1'b1,
                dq_oe_n: 1'b1, rdata: 8'h00, ser_go: 1'b0,
                mode_s: 2'h0, sda_s: 2'h3};
      end else begin
         r <= next_r;
      end
   end
   // registered read data: offset selects byte, top bit is busy
   logic [7:0] rd_q;
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rd_q <= 8'h00;
      end else if (REG_RD && REG_OFS == NV_ADDR_DATA_OFS) begin
         rd_q <= r.hold;
      end else if (REG_RD && REG_OFS == NV_ACCESS_CTRL_OFS) begin
         rd_q <= {r.busy, r.ctrl[1:0], 5'h00};
      end else if (REG_RD) begin
         rd_q <= 8'h00;
      end
   end
   // the serial engine's outputs are themselves flops
   logic scl_q;
   logic sda_q;
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= ser_scl_oe_n;
         sda_q <= ser_sda_oe_n;
      end
   end
   assign REG_RDATA = rd_q;
   assign ROM_ACK = r.rom_ack;
   assign ROM_RDATA = r.rom_word;
   assign NV_ADDRESS_BUS = r.cur_addr;
   assign NV_DATA_BUS_OUT = r.dat;
   assign NV_DATA_BUS_OE_N = r.dq_oe_n;
   assign NV_READ_STROBE_N = r.rd_n;
   assign NV_WRITE_STROBE_N = r.wr_n;
   assign SCL_OE_N = scl_q;
   assign SDA_OE_N = sda_q;
endmodule : nvap_port

/* File: rtl/nvap_serial.sv */
`timescale 1ns/10ps
// two-wire byte engine: writes or reads one byte at a 16-bit address
module nvap_serial
   import nvap_pkg::*;
#(
   parameter int DIVIDE = nvap_pkg::SCL_DIVIDE
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic is_read,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic sda_in,
   output logic scl_oe_n,
   output logic sda_oe_n,
   output logic done,
   output logic [7:0] rdata
);
   localparam int QTR = DIVIDE / 4;
   initial begin
      if (DIVIDE < 8 || DIVIDE % 4 != 0) begin
         $error("nvap_serial: DIVIDE must be a multiple of 4, at least 8");
      end
   end
   // one bit slot per entry: 4 phases each; sequence is a flat bit script
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_RUN = 3'b010,
      S_DONE = 3'b100
   } nvs_state_t;
   typedef struct packed {
      nvs_state_t st;
      logic [15:0] cnt;
      logic [1:0] ph;
      logic [6:0] bitn;
      logic [7:0] rd;
      logic scl;
      logic sda;
      logic done;
   } nvs_t;
   nvs_t r, next_r;
   logic [6:0] last_bit;
   // script: 0 start, 1..9 dev+w+ack, 10..18 ahi, 19..27 alo,
   // write: 28..36 data, 37 stop
   // read: 28 restart, 29..37 dev+r+ack, 38..46 data+nack, 47 stop
   function automatic logic [2:0] slot(input logic [6:0] n, input logic rdx,
         input logic [15:0] a, input logic [7:0] d);
      // returns {kind, value}: kind 0 data, 1 start, 2 stop, 3 read
      logic [7:0] byt;
      logic [3:0] k;
      byt = 8'h00;
      k = 4'h0;
      slot = 3'h0;
      if (n == 7'd0 || (rdx && n == 7'd28)) begin
         slot = 3'b010;
      end else if ((!rdx && n == 7'd37) || (rdx && n == 7'd47)) begin
         slot = 3'b100;
      end else begin
         if (n < 7'd10) begin
            byt = {SER_DEV_READ, 1'b0};
            k = 4'(n - 7'd1);
         end else if (n < 7'd19) begin
            byt = a[15:8];
            k = 4'(n - 7'd10);
         end else if (n < 7'd28) begin
            byt = a[7:0];
            k = 4'(n - 7'd19);
         end else if (!rdx) begin
            byt = d;
            k = 4'(n - 7'd28);
         end else if (n < 7'd38) begin
            byt = {SER_DEV_READ, 1'b1};
            k = 4'(n - 7'd29);
         end else begin
            k = 4'(n - 7'd38);
            slot = (k == 4'd8) ? 3'b001 : 3'b110;
         end
         if (!(rdx && n >= 7'd38)) begin
            slot = (k == 4'd8) ? 3'b001 : {2'b00, byt[3'(4'd7 - k)]};
         end
      end
   endfunction : slot
   logic [2:0] cur;
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      last_bit = is_read ? 7'd47 : 7'd37;
      cur = slot(r.bitn, is_read, addr, wdata);
      case (r.st)
         S_IDLE: begin
            next_r.scl = 1'b1;
            next_r.sda = 1'b1;
            if (start) begin
               next_r.st = S_RUN;
               next_r.bitn = 7'd0;
               next_r.ph = 2'd0;
               next_r.cnt = 16'd0;
            end
         end
         S_RUN: begin
            next_r.cnt = r.cnt + 16'd1;
            if (r.cnt == 16'(QTR - 1)) begin
               next_r.cnt = 16'd0;
               next_r.ph = r.ph + 2'd1;
               case (cur)
                  3'b010: begin
                     // start/restart: sda falls while scl high
                     next_r.scl = (r.ph != 2'd3);
                     next_r.sda = (r.ph == 2'd0);
                  end
                  3'b100: begin
                     next_r.scl = (r.ph != 2'd0);
                     next_r.sda = (r.ph >= 2'd2);
                  end
                  3'b110: begin
                     next_r.sda = 1'b1;
                     next_r.scl = (r.ph == 2'd0 || r.ph == 2'd1);
                     if (r.ph == 2'd1) begin
                        next_r.rd = {r.rd[6:0], sda_in};
                     end
                  end
                  default: begin
                     // ack slots release sda; last read ack is a nack
                     next_r.sda = cur[0] | (cur == 3'b001);
                     next_r.scl = (r.ph == 2'd0 || r.ph == 2'd1);
                  end
               endcase
               if (r.ph == 2'd3) begin
                  if (r.bitn == last_bit) begin
                     next_r.st = S_DONE;
                  end else begin
                     next_r.bitn = r.bitn + 7'd1;
                  end
               end
            end
         end
         S_DONE: begin
            next_r.done = 1'b1;
            next_r.st = S_IDLE;
         end
         default: next_r.st = S_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{st: S_IDLE, cnt: 16'h0000, ph: 2'h0, bitn: 7'h00,
                rd: 8'h00, scl: 1'b1, sda: 1'b1, done: 1'b0};
      end else begin
         r <= next_r;
      end
   end
   // open drain: enable low pulls the line low
   assign scl_oe_n = r.scl;
   assign sda_oe_n = r.sda;
   assign done = r.done;
   assign rdata = r.rd;
endmodule : nvap_serial

/* File: sim/nvap_mem_model.sv */
`timescale 1ns/10ps
module nvap_mem_model (
   input wire logic clk,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic rd_n,
   input wire logic wr_n,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] held;
   initial begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
      held = 8'h00;
   end
   // released bus shows the inverse of the last byte, never a stale copy
   assign rdata = rd_n ? ~held : mem[addr];
   always @(posedge clk) begin
      if (!rd_n)
         held <= mem[addr];
      if (!wr_n)
         mem[addr] <= wdata;
   end
endmodule : nvap_mem_model

/* File: sim/nvap_port_sva.sv */
`timescale 1ns/10ps
module nvap_port_chk #(
   parameter int BW_LEN = 8
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic SERIAL_MODE,
   input wire logic ROM_RD,
   input wire logic ROM_WR,
   input wire logic ROM_ACK,
   input wire logic [15:0] NV_ADDRESS_BUS,
   input wire logic NV_DATA_BUS_OE_N,
   input wire logic NV_READ_STROBE_N,
   input wire logic NV_WRITE_STROBE_N,
   input wire logic SCL_OE_N,
   input wire logic SDA_OE_N
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);
   // read strobe falls seen during one rom request
   logic [2:0] rom_falls;
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N)
         rom_falls <= 3'h0;
      else if (!ROM_RD)
         rom_falls <= 3'h0;
      else if ($fell(NV_READ_STROBE_N))
         rom_falls <= rom_falls + 3'h1;
   end
   chk_strobe_excl: assert property (
      NV_READ_STROBE_N || NV_WRITE_STROBE_N)
      else $error("both memory strobes low");
   chk_read_len: assert property (
      $fell(NV_READ_STROBE_N) |-> !NV_READ_STROBE_N[*6] ##1 NV_READ_STROBE_N)
      else $error("read strobe width wrong");
   chk_read_addr: assert property (
      !NV_READ_STROBE_N |-> $stable(NV_ADDRESS_BUS) && NV_DATA_BUS_OE_N)
      else $error("address moved or bus driven during read");
   chk_write_addr: assert property (
      !NV_WRITE_STROBE_N |-> $stable(NV_ADDRESS_BUS) && !NV_DATA_BUS_OE_N)
      else $error("address moved or data undriven during write");
   chk_rom_four: assert property (
      ROM_ACK && ROM_RD |-> rom_falls == 3'h4)
      else $error("rom word not built from four byte reads");
   chk_rom_wr_ack: assert property (
      $rose(ROM_WR) |=> ROM_ACK)
      else $error("rom write not acknowledged next cycle");
   chk_rom_wr_safe: assert property (
      ROM_WR |-> NV_WRITE_STROBE_N)
      else $error("rom window write reached memory");
   chk_ack_pulse: assert property (
      ROM_ACK |=> !ROM_ACK)
      else $error("rom acknowledge longer than one cycle");
   chk_serial_quiet: assert property (
      !SERIAL_MODE |-> SCL_OE_N && SDA_OE_N)
      else $error("serial lines pulled in byte-wide mode");
   chk_byte_quiet: assert property (
      SERIAL_MODE |-> NV_READ_STROBE_N && NV_WRITE_STROBE_N)
      else $error("byte-wide strobe active in serial mode");
   cover property ($fell(NV_READ_STROBE_N));
   cover property ($fell(NV_WRITE_STROBE_N));
   cover property (ROM_ACK && ROM_RD);
   cover property (SERIAL_MODE && $fell(SCL_OE_N));
endmodule : nvap_port_chk

bind nvap_port nvap_port_chk #(.BW_LEN(BW_LEN)) u_nvap_port_chk (
   .CLK_SYS(CLK_SYS),
   .RST_N(RST_N),
   .SERIAL_MODE(SERIAL_MODE),
   .ROM_RD(ROM_RD),
   .ROM_WR(ROM_WR),
   .ROM_ACK(ROM_ACK),
   .NV_ADDRESS_BUS(NV_ADDRESS_BUS),
   .NV_DATA_BUS_OE_N(NV_DATA_BUS_OE_N),
   .NV_READ_STROBE_N(NV_READ_STROBE_N),
   .NV_WRITE_STROBE_N(NV_WRITE_STROBE_N),
   .SCL_OE_N(SCL_OE_N),
   .SDA_OE_N(SDA_OE_N)
);

/* File: sim/tb_nvap_port.sv */
`timescale 1ns/10ps
module tb_nvap_port;
   import nvap_pkg::*;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic [7:0] exp;
   } nvap_row_t;
   logic clk_sys, rst_n, reg_wr, reg_rd, rom_rd, rom_wr, rom_ack;
   logic rd_n, wr_n, oe_n, scl_oe_n, sda_oe_n, serial_mode;
   time t0;
   logic [1:0] reg_be;
   logic [7:0] reg_ofs, reg_rdata, dout, din, b;
   logic [15:0] reg_wdata, rom_addr, nv_addr;
   logic [31:0] rom_rdata, rom_word;
   int fails, comparisons;
   nvap_row_t rows [4];
   nvap_port u_nvap_port (.CLK_SYS(clk_sys), .RST_N(rst_n),
      .SERIAL_MODE(serial_mode), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_OFS(reg_ofs), .REG_BE(reg_be), .REG_WDATA(reg_wdata),
      .REG_RDATA(reg_rdata), .ROM_RD(rom_rd), .ROM_WR(rom_wr),
      .ROM_ADDR(rom_addr), .ROM_ACK(rom_ack), .ROM_RDATA(rom_rdata),
      .NV_ADDRESS_BUS(nv_addr), .NV_DATA_BUS_OUT(dout),
      .NV_DATA_BUS_OE_N(oe_n), .NV_DATA_BUS_IN(din),
      .NV_READ_STROBE_N(rd_n), .NV_WRITE_STROBE_N(wr_n),
      // data line with pull-up only: no serial memory answers
      .SCL_OE_N(scl_oe_n), .SDA_OE_N(sda_oe_n), .SDA_IN(sda_oe_n));
   nvap_mem_model u_nvap_mem_model (.clk(clk_sys), .addr(nv_addr),
      .wdata(dout), .rd_n(rd_n), .wr_n(wr_n), .rdata(din));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   function automatic logic [7:0] mem_at(input logic [15:0] a);
      return u_nvap_mem_model.mem[a];
   endfunction : mem_at
   task automatic chk_byte(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk_byte
   task automatic chk_word(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk_word
   task automatic wr(input logic [7:0] ofs, input logic [1:0] be,
      input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_ofs <= ofs;
      reg_be <= be;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic ctl(input logic [7:0] c);
      wr(8'h3f, 2'b01, {8'h00, c});
   endtask : ctl
   task automatic dat(input logic [7:0] d);
      wr(8'h3e, 2'b01, {8'h00, d});
   endtask : dat
   task automatic rd(input logic [7:0] ofs, output logic [7:0] q);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_ofs <= ofs;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      #1 q = reg_rdata;
   endtask : rd
   task automatic wait_idle;
      logic [7:0] s;
      s = 8'h80;
      for (int i = 0; i < 8000 && s[7] !== 1'b0; i++)
         rd(8'h3f, s);
      chk_byte("busy bit", 8'h00, s & 8'h80);
   endtask : wait_idle
   task automatic read_check(input string what, input logic [7:0] exp);
      wait_idle();
      rd(8'h3e, b);
      chk_byte(what, exp, b);
   endtask : read_check
   task automatic rom_req(input logic wr_req);
      @(posedge clk_sys);
      rom_addr <= 16'h0040;
      rom_rd <= !wr_req;
      rom_wr <= wr_req;
      #1;
      for (int i = 0; i < 400 && rom_ack !== 1'b1; i++)
         @(posedge clk_sys) #1;
      rom_word = rom_rdata;
      chk_byte("rom ack", 8'h01, {7'h0, rom_ack});
      @(posedge clk_sys);
      rom_rd <= 1'b0;
      rom_wr <= 1'b0;
   endtask : rom_req
   task automatic give_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   initial begin
      #(20 * 60000);
      fails++;
      give_verdict();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, rom_rd, rom_wr, serial_mode} = '0;
      {reg_be, reg_ofs, reg_wdata, rom_addr} = '0;
      fails = 0;
      comparisons = 0;
      rows = '{'{16'h0040, 8'ha5, 8'ha5}, '{16'h0041, 8'h3c, 8'h3c},
         '{16'hff00, 8'h5e, 8'h5e}, '{16'h00ff, 8'hc3, 8'hc3}};
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      foreach (rows[i]) begin
         ctl(8'h80);
         dat(rows[i].addr[7:0]);
         ctl(8'ha0);
         dat(rows[i].addr[15:8]);
         ctl(8'h00);
         dat(rows[i].data);
         ctl(8'hc0);
         wait_idle();
         chk_byte("memory", rows[i].exp, mem_at(rows[i].addr));
         ctl(8'he0);
         read_check("read back", rows[i].exp);
      end
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 chk_byte("reset pins", 8'hf8,
         {rd_n, wr_n, oe_n, scl_oe_n, sda_oe_n, rom_ack, 2'b00});
      chk_word("reset address", 32'h0, {16'h0, nv_addr});
      @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(8'h3d, b);
      chk_byte("unmapped read", 8'h00, b);
      rd(8'h3e, b);
      chk_byte("latch reset", LATCH_RESET, b);
      ctl(8'h80);
      dat(8'h11);
      dat(8'h41);
      ctl(8'ha0);
      dat(8'h00);
      ctl(8'he0);
      read_check("last byte wins", rows[1].exp);
      ctl(8'h80);
      dat(8'h40);
      ctl(8'he0);
      read_check("high byte kept", rows[0].exp);
      wr(8'h3e, 2'b11, 16'h8000);
      wr(8'h3e, 2'b11, 16'ha0ff);
      wr(8'h3e, 2'b11, 16'he000);
      read_check("wide write", rows[3].exp);
      ctl(8'h80);
      dat(8'h40);
      ctl(8'ha0);
      dat(8'h00);
      ctl(8'he0);
      ctl(8'hc0);
      rd(8'h3f, b);
      chk_byte("busy during read", 8'h80, b & 8'h80);
      read_check("start ignored", rows[0].exp);
      chk_byte("memory kept", rows[0].exp, mem_at(16'h0040));
      rom_req(1'b0);
      chk_word("rom word", {mem_at(16'h0043), mem_at(16'h0042),
         mem_at(16'h0041), mem_at(16'h0040)}, rom_word);
      rom_req(1'b1);
      chk_byte("rom write", rows[0].exp, mem_at(16'h0040));
      @(posedge clk_sys);
      serial_mode <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ctl(8'hc0);
      // first clock low after the start bit is short: time the next one
      @(negedge scl_oe_n);
      @(negedge scl_oe_n);
      t0 = $time;
      @(negedge scl_oe_n);
      t0 = ($time - t0) / 20;
      chk_word("scl period", 32'(SCL_DIVIDE), 32'(t0));
      wait_idle();
      chk_byte("serial lines", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
      give_verdict();
   end
endmodule : tb_nvap_port
